// *** src/cfg_otp_pkg.sv ***
// shared constants and types for the configuration-mode command handler
package cfg_otp_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_USER = 4'h0;
  localparam logic [3:0] ADDR_CFG_A = 4'h1;
  localparam logic [3:0] ADDR_CFG_B = 4'h2;
  localparam logic [3:0] ADDR_CFG_C = 4'h3;
  localparam logic [3:0] ADDR_EXIT = 4'hA;
  localparam logic [3:0] ADDR_SN0 = 4'hB;
  localparam logic [3:0] ADDR_SN3 = 4'hE;
  localparam logic [3:0] ADDR_MFG_ID = 4'hF;
  localparam logic [3:0] ADDR_LAST_RAM = 4'h3;

  // ----------------------------------------------------------------
  // field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0] EXIT_VALUE = 8'h80;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] LOCK_MASK = 8'h80;
  localparam logic [2:0] SV_NORMAL = 3'h5;
  localparam logic [2:0] SV_ERROR = 3'h6;
  localparam logic [1:0] START_BITS = 2'h2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_ADDR = 4'h0;
  localparam logic [7:0] RAM_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FUSE_PROGRAM_TIME_US = 12000;
  localparam int FUSE_PROGRAM_CYCLES = FUSE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int FUSE_BYTES = 4;
  localparam int TIMER_W = 22;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_CFG = 4'b0100,
    ST_PROG = 4'b1000
  } state_e;

  localparam int ST_CFG_BIT = 2;
  localparam int ST_PROG_BIT = 3;

  // command frame, bit 0 received first
  typedef struct packed {
    logic parity;
    logic [7:0] data;
    logic [3:0] addr;
    logic rw;
  } cmd_s;

  // handshake frame, bit 0 transmitted first
  typedef struct packed {
    logic parity;
    logic [3:0] addr;
    logic [7:0] data;
    logic [2:0] sv;
    logic [1:0] start;
  } hs_s;

  typedef logic [FUSE_BYTES-1:0][7:0] cu_bytes_t;

  typedef struct packed {
    state_e st;
    cu_bytes_t ram;
    logic locked;
    logic [1:0] idx;
    logic [TIMER_W-1:0] timer;
    logic hs_valid;
    hs_s hs;
    logic fuse_we;
    logic [1:0] fuse_addr;
    logic [7:0] fuse_data;
    logic restart;
  } state_s;

endpackage

// *** src/config_mode_otp_handshake.sv ***
// configuration-mode command handler with handshake replies and fuse programming
// How it works
// - every complete command in configuration mode gets one handshake
// - handshake data from RAM or fuses
// - parity error: state 110, zero data/address
// - unlocked write stores, returns read-back value
// - locked write ignored, returns fuse contents
// - read ignores data, returns RAM contents
// - RAM holds writes, or fuses once programmed
// - write 0x80 to exit address, still handshake
// - exit restarts phase 1, no reset
// - serial number and fixed ID readable
// - lock bit write programs four fuse bytes
// - programming takes about 12 ms
// - commands ignored during programming
// - programming done: handshake with third config register
// - programmed fuses copied to RAM at startup
// - device sets lock bit at end
// - lock bit reads programmed state, blocks writes
// - user register inert, config registers drive outputs
// - 18-bit handshake frame, even parity, LSB first
// - command frame: rw, address, data, parity
// - normal handshakes carry state 101
`timescale 1ns/1ps

module config_mode_otp_handshake #(
  parameter int FUSE_PROG_CYCLES = cfg_otp_pkg::FUSE_PROGRAM_CYCLES,
  parameter logic [7:0] MFG_ID = 8'h5C // arbitrary identification value
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_enter,
  input wire logic cmd_valid,
  input wire cfg_otp_pkg::cmd_s cmd,
  input wire logic [31:0] serial_number,
  input wire cfg_otp_pkg::cu_bytes_t fuse_rd,
  input wire logic fuse_locked,
  output logic hs_valid,
  output cfg_otp_pkg::hs_s hs_frame,
  output logic in_config,
  output logic programming,
  output logic otp_locked,
  output logic phase1_start,
  output logic fuse_we,
  output logic [1:0] fuse_addr,
  output logic [7:0] fuse_data,
  output logic [7:0] config_reg_a,
  output logic [7:0] config_reg_b,
  output logic [7:0] config_reg_c
);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // each of the four bytes gets a quarter of the programming time
  localparam int STEP_INT = (FUSE_PROG_CYCLES / cfg_otp_pkg::FUSE_BYTES) < 1 ? 1 :
                            (FUSE_PROG_CYCLES / cfg_otp_pkg::FUSE_BYTES);
  localparam logic [cfg_otp_pkg::TIMER_W-1:0] STEP_LOAD = cfg_otp_pkg::TIMER_W'(STEP_INT - 1);

  cfg_otp_pkg::state_s s_q;
  cfg_otp_pkg::state_s s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic cfg_otp_pkg::hs_s make_hs(input logic [3:0] a, input logic [7:0] d, input logic [2:0] sv);
    cfg_otp_pkg::hs_s h;
    h.start = cfg_otp_pkg::START_BITS;
    h.addr = a;
    h.data = d;
    h.sv = sv;
    h.parity = ^{a, d, sv};
    return h;
  endfunction

  function automatic logic [7:0] read_reg(input logic [3:0] a, input cfg_otp_pkg::cu_bytes_t ram,
                                          input logic [31:0] sn);
    logic [7:0] v;
    v = cfg_otp_pkg::ZERO_BYTE;
    if (a <= cfg_otp_pkg::ADDR_LAST_RAM) begin
      v = ram[a[1:0]];
    end else if (a >= cfg_otp_pkg::ADDR_SN0 && a <= cfg_otp_pkg::ADDR_SN3) begin
      v = sn[8*(a - cfg_otp_pkg::ADDR_SN0) +: 8];
    end else if (a == cfg_otp_pkg::ADDR_MFG_ID) begin
      v = MFG_ID;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] lock_byte;
    lock_byte = s_q.ram[cfg_otp_pkg::ADDR_CFG_C[1:0]] | cfg_otp_pkg::LOCK_MASK;
    s_d = s_q;
    s_d.hs_valid = 1'b0;
    s_d.fuse_we = 1'b0;
    s_d.restart = 1'b0;
    case (s_q.st)
      cfg_otp_pkg::ST_INIT: begin
        // phase 1: fuses overwrite RAM only when programmed
        if (fuse_locked) begin
          s_d.ram = fuse_rd;
        end
        s_d.locked = fuse_locked;
        s_d.st = cfg_otp_pkg::ST_RUN;
      end
      cfg_otp_pkg::ST_RUN: begin
        if (cfg_enter) begin
          s_d.st = cfg_otp_pkg::ST_CFG;
          s_d.hs_valid = 1'b1;
          s_d.hs = make_hs(cfg_otp_pkg::ADDR_CFG_C, s_q.ram[cfg_otp_pkg::ADDR_CFG_C[1:0]], cfg_otp_pkg::SV_NORMAL);
        end
      end
      cfg_otp_pkg::ST_CFG: begin
        if (cmd_valid) begin
          s_d.hs_valid = 1'b1;
          if (^cmd) begin
            s_d.hs = make_hs(cfg_otp_pkg::ZERO_ADDR, cfg_otp_pkg::ZERO_BYTE, cfg_otp_pkg::SV_ERROR);
          end else if (cmd.rw) begin
            s_d.hs = make_hs(cmd.addr, read_reg(cmd.addr, s_q.ram, serial_number), cfg_otp_pkg::SV_NORMAL);
          end else if (cmd.addr == cfg_otp_pkg::ADDR_EXIT) begin
            s_d.hs = make_hs(cmd.addr, cmd.data, cfg_otp_pkg::SV_NORMAL);
            if (cmd.data == cfg_otp_pkg::EXIT_VALUE) begin
              // back to phase 1 without touching the reset
              s_d.st = cfg_otp_pkg::ST_INIT;
              s_d.restart = 1'b1;
            end
          end else if (cmd.addr <= cfg_otp_pkg::ADDR_LAST_RAM) begin
            if (s_q.locked) begin
              s_d.hs = make_hs(cmd.addr, fuse_rd[cmd.addr[1:0]], cfg_otp_pkg::SV_NORMAL);
            end else begin
              s_d.ram[cmd.addr[1:0]] = cmd.data;
              s_d.hs = make_hs(cmd.addr, cmd.data, cfg_otp_pkg::SV_NORMAL);
              if (cmd.addr == cfg_otp_pkg::ADDR_CFG_C && cmd.data[cfg_otp_pkg::LOCK_BIT]) begin
                // acknowledge comes at the end of programming instead
                s_d.hs_valid = 1'b0;
                s_d.st = cfg_otp_pkg::ST_PROG;
                s_d.idx = 2'd0;
                s_d.timer = STEP_LOAD;
              end
            end
          end else begin
            // read-only or unused address: write has no effect
            s_d.hs = make_hs(cmd.addr, read_reg(cmd.addr, s_q.ram, serial_number), cfg_otp_pkg::SV_NORMAL);
          end
        end
      end
      cfg_otp_pkg::ST_PROG: begin
        // commands are dropped here; the tester must wait for the ack
        if (s_q.timer != '0) begin
          s_d.timer = s_q.timer - 1'b1;
        end else begin
          s_d.fuse_we = 1'b1;
          s_d.fuse_addr = s_q.idx;
          s_d.fuse_data = (s_q.idx == cfg_otp_pkg::ADDR_CFG_C[1:0]) ? lock_byte : s_q.ram[s_q.idx];
          if (s_q.idx == cfg_otp_pkg::ADDR_CFG_C[1:0]) begin
            s_d.locked = 1'b1;
            s_d.ram[cfg_otp_pkg::ADDR_CFG_C[1:0]] = lock_byte;
            s_d.st = cfg_otp_pkg::ST_CFG;
            s_d.hs_valid = 1'b1;
            s_d.hs = make_hs(cfg_otp_pkg::ADDR_CFG_C, lock_byte, cfg_otp_pkg::SV_NORMAL);
          end else begin
            s_d.idx = s_q.idx + 2'd1;
            s_d.timer = STEP_LOAD;
          end
        end
      end
      default: begin
        s_d.st = cfg_otp_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: cfg_otp_pkg::ST_INIT, ram: {cfg_otp_pkg::FUSE_BYTES{cfg_otp_pkg::RAM_RESET}}, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the user register is kept but drives nothing
  assign config_reg_a = s_q.ram[cfg_otp_pkg::ADDR_CFG_A[1:0]];
  assign config_reg_b = s_q.ram[cfg_otp_pkg::ADDR_CFG_B[1:0]];
  assign config_reg_c = s_q.ram[cfg_otp_pkg::ADDR_CFG_C[1:0]];
  assign hs_valid = s_q.hs_valid;
  assign hs_frame = s_q.hs;
  assign in_config = s_q.st[cfg_otp_pkg::ST_CFG_BIT];
  assign programming = s_q.st[cfg_otp_pkg::ST_PROG_BIT];
  assign otp_locked = s_q.locked;
  assign phase1_start = s_q.restart;
  assign fuse_we = s_q.fuse_we;
  assign fuse_addr = s_q.fuse_addr;
  assign fuse_data = s_q.fuse_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic cmd_in_cfg;
  logic good_write;
  assign cmd_in_cfg = cmd_valid && s_q.st == cfg_otp_pkg::ST_CFG;
  assign good_write = cmd_in_cfg && !(^cmd) && !cmd.rw && cmd.addr <= cfg_otp_pkg::ADDR_LAST_RAM;

  chk_parity_err_reply: assert property (cmd_in_cfg && (^cmd) |=> hs_valid && hs_frame.sv == cfg_otp_pkg::SV_ERROR
    && hs_frame.data == 8'h00 && hs_frame.addr == 4'h0)
    else $error("parity error reply malformed");
  chk_normal_state_vec: assert property (hs_valid && hs_frame.addr != 4'h0 |-> hs_frame.sv == cfg_otp_pkg::SV_NORMAL)
    else $error("normal reply without state 101");
  chk_frame_even_parity: assert property (hs_valid |-> !(^hs_frame[17:2]) && hs_frame.start == 2'h2)
    else $error("handshake parity or start bits wrong");
  chk_write_read_back: assert property (good_write && !s_q.locked && !(cmd.addr == 4'h3 && cmd.data[7])
    |=> hs_valid && hs_frame.data == $past(cmd.data) && s_q.ram[hs_frame.addr[1:0]] == hs_frame.data)
    else $error("write read-back mismatch");
  chk_locked_write_ignored: assert property (good_write && s_q.locked
    |=> $stable(s_q.ram) && hs_valid && hs_frame.data == fuse_rd[hs_frame.addr[1:0]])
    else $error("locked write changed RAM or wrong data");
  chk_prog_ignores_cmd: assert property (programming && s_q.timer != '0 |=> !hs_valid)
    else $error("reply while programming");
  chk_prog_done_ack: assert property (programming && s_q.timer == '0 && s_q.idx == 2'd3
    |=> hs_valid && otp_locked && hs_frame.addr == 4'h3 && hs_frame.data[7] && in_config)
    else $error("programming end not acknowledged");
  chk_exit_restart: assert property (cmd_in_cfg && !(^cmd) && !cmd.rw && cmd.addr == 4'hA && cmd.data == 8'h80
    |=> hs_valid && phase1_start ##1 !in_config ##1 !in_config && !phase1_start)
    else $error("exit did not handshake and restart");
  chk_init_fuse_load: assert property (arst_n && s_q.st == cfg_otp_pkg::ST_INIT && fuse_locked
    |=> s_q.ram == $past(fuse_rd) && otp_locked)
    else $error("fuses not loaded at start-up");
  chk_read_from_ram: assert property (cmd_in_cfg && !(^cmd) && cmd.rw && cmd.addr <= 4'h3
    |=> hs_valid && hs_frame.data == s_q.ram[hs_frame.addr[1:0]])
    else $error("read not served from RAM");
  chk_prog_bytes: assert property ($rose(programming) |-> !fuse_we [*2])
    else $error("fuse byte written too early");

  cov_parity_error: cover property (cmd_in_cfg && (^cmd) ##1 hs_valid);
  cov_program_done: cover property (programming ##1 !programming && otp_locked);
  cov_exit: cover property (phase1_start);
  cov_locked_write: cover property (good_write && s_q.locked);
  cov_serial_read: cover property (cmd_in_cfg && cmd.rw && cmd.addr == cfg_otp_pkg::ADDR_SN3 ##1 hs_valid);

  // ----------------------------------------------------------------
  // checks: replies and register access
  // ----------------------------------------------------------------
  // the lock write is the one command answered late, by the end of programming
  logic lock_write;
  assign lock_write = good_write && !s_q.locked && cmd.addr == cfg_otp_pkg::ADDR_CFG_C
    && cmd.data[cfg_otp_pkg::LOCK_BIT];

  chk_cmd_gets_reply: assert property (cmd_in_cfg && !lock_write
    |=> hs_valid)
    else $error("command without handshake");
  chk_no_stray_reply: assert property (!cmd_in_cfg && !(s_q.st == cfg_otp_pkg::ST_RUN && cfg_enter)
    && !(programming && s_q.timer == '0 && s_q.idx == 2'd3) |=> !hs_valid)
    else $error("handshake without a cause");
  chk_enter_reply: assert property (s_q.st == cfg_otp_pkg::ST_RUN && cfg_enter
    |=> hs_valid && in_config && hs_frame.addr == cfg_otp_pkg::ADDR_CFG_C && hs_frame.data == $past(config_reg_c))
    else $error("entry handshake wrong");
  chk_parity_err_inert: assert property (cmd_in_cfg && (^cmd)
    |=> $stable(s_q.ram) && in_config)
    else $error("bad frame changed state");
  chk_error_fields_zero: assert property (hs_valid && hs_frame.sv == cfg_otp_pkg::SV_ERROR
    |-> hs_frame.addr == cfg_otp_pkg::ZERO_ADDR && hs_frame.data == cfg_otp_pkg::ZERO_BYTE)
    else $error("error reply carries data");
  chk_read_keeps_ram: assert property (cmd_in_cfg && !(^cmd) && cmd.rw
    |=> $stable(s_q.ram) && hs_frame.addr == $past(cmd.addr))
    else $error("read changed RAM or address");
  chk_read_only_inert: assert property (cmd_in_cfg && !(^cmd) && !cmd.rw && cmd.addr > cfg_otp_pkg::ADDR_LAST_RAM
    |=> $stable(s_q.ram))
    else $error("write to read-only address changed RAM");
  chk_mfg_id_fixed: assert property (cmd_in_cfg && !(^cmd) && cmd.addr == cfg_otp_pkg::ADDR_MFG_ID
    |=> hs_frame.data == MFG_ID)
    else $error("identification value not fixed");
  chk_serial_read: assert property (cmd_in_cfg && !(^cmd) && cmd.rw && cmd.addr >= cfg_otp_pkg::ADDR_SN0
    && cmd.addr <= cfg_otp_pkg::ADDR_SN3 |=> hs_frame.data == 8'(serial_number >> {hs_frame.addr - cfg_otp_pkg::ADDR_SN0, 3'b000}))
    else $error("serial number byte wrong");
  chk_config_reg_write: assert property (good_write && !s_q.locked && cmd.addr == cfg_otp_pkg::ADDR_CFG_A
    |=> config_reg_a == $past(cmd.data))
    else $error("config register a not updated");
  chk_user_reg_inert: assert property (good_write && !s_q.locked && cmd.addr == cfg_otp_pkg::ADDR_USER
    |=> $stable(config_reg_a) && $stable(config_reg_b) && $stable(config_reg_c))
    else $error("user write moved a config output");

  // ----------------------------------------------------------------
  // checks: fuse programming
  // ----------------------------------------------------------------
  // each byte gets a full step, so the timer is reloaded at every burn but the last
  chk_lock_write_starts: assert property (lock_write
    |=> programming && !hs_valid && s_q.idx == 2'd0)
    else $error("lock write did not start programming");
  chk_prog_countdown: assert property (programming && s_q.timer != '0
    |=> programming && s_q.timer == $past(s_q.timer) - 1'b1)
    else $error("programming timer not counting down");
  chk_step_reload: assert property (fuse_we && programming
    |-> s_q.timer == STEP_LOAD)
    else $error("byte step not reloaded");
  chk_prog_ram_frozen: assert property (programming && s_q.timer != '0
    |=> $stable(s_q.ram))
    else $error("RAM changed while programming");
  chk_prog_unlocked: assert property (programming
    |-> !otp_locked && !in_config)
    else $error("programming while locked or accepting commands");
  chk_burn_order: assert property (fuse_we && fuse_addr != 2'd3
    |-> programming && fuse_data == s_q.ram[fuse_addr])
    else $error("fuse byte does not match RAM");
  chk_lock_byte_burn: assert property (fuse_we && fuse_addr == 2'd3
    |-> fuse_data[cfg_otp_pkg::LOCK_BIT] && hs_valid && otp_locked)
    else $error("last fuse byte without lock");
  chk_locked_no_prog: assert property (otp_locked && cmd_in_cfg
    |=> !programming)
    else $error("programming restarted after lock");
  chk_locked_sticky: assert property (otp_locked
    |=> otp_locked)
    else $error("lock bit cleared");

  // ----------------------------------------------------------------
  // checks: exit and start-up
  // ----------------------------------------------------------------
  // reset is released on a clock edge, so start-up antecedents need it sampled high
  chk_restart_pulse: assert property (phase1_start
    |-> s_q.st == cfg_otp_pkg::ST_INIT && !in_config ##1 !phase1_start)
    else $error("restart pulse malformed");
  chk_exit_reply_echo: assert property (cmd_in_cfg && !(^cmd) && !cmd.rw && cmd.addr == cfg_otp_pkg::ADDR_EXIT
    |=> hs_frame.addr == cfg_otp_pkg::ADDR_EXIT && hs_frame.data == $past(cmd.data))
    else $error("exit address reply wrong");
  chk_exit_other_stays: assert property (cmd_in_cfg && !(^cmd) && cmd.addr == cfg_otp_pkg::ADDR_EXIT
    && !cmd.rw && cmd.data != cfg_otp_pkg::EXIT_VALUE |=> in_config && !phase1_start)
    else $error("non-exit value left configuration");
  chk_init_one_cycle: assert property (arst_n && s_q.st == cfg_otp_pkg::ST_INIT
    |=> s_q.st == cfg_otp_pkg::ST_RUN)
    else $error("start-up did not leave initialisation");
  chk_unlocked_init_keeps: assert property (arst_n && s_q.st == cfg_otp_pkg::ST_INIT && !fuse_locked
    |=> $stable(s_q.ram) && !otp_locked)
    else $error("unprogrammed start-up changed RAM");

endmodule

// *** tb/fuse_model.sv ***
// behavioural one-time-programmable fuse array behind the handler
`timescale 1ns/1ps
module fuse_model (
  input wire logic clk,
  input wire logic fuse_we,
  input wire logic [1:0] fuse_addr,
  input wire logic [7:0] fuse_data,
  output cfg_otp_pkg::cu_bytes_t fuse_rd,
  output logic fuse_locked
);
  // no reset input: fuse contents survive a power-on reset
  initial begin
    fuse_rd = '0;
    fuse_locked = 1'b0;
  end

  // once the lock byte lands the array refuses any further burn
  always @(posedge clk) begin
    if (fuse_we && !fuse_locked) begin
      fuse_rd[fuse_addr] <= fuse_data;
      if (fuse_addr == 2'h3 && fuse_data[7]) begin
        fuse_locked <= 1'b1;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the configuration-mode command handler
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] ID_VAL = 8'h5c; // arbitrary identification value
  logic clk, arst_n, cfg_enter, cmd_valid, fuse_locked, hs_valid, in_config;
  logic programming, otp_locked, phase1_start, fuse_we;
  cfg_otp_pkg::cmd_s cmd;
  cfg_otp_pkg::hs_s hs_frame, hs;
  cfg_otp_pkg::cu_bytes_t fuse_rd;
  logic [31:0] serial_number;
  logic [1:0] fuse_addr;
  logic [7:0] fuse_data, config_reg_a, config_reg_b, config_reg_c;
  int n_fail = 0;
  int total_checks = 0;
  int n_cyc, n_we;

  config_mode_otp_handshake #(.FUSE_PROG_CYCLES(8), .MFG_ID(ID_VAL)) config_mode_otp_handshake_inst (
    .clk(clk), .arst_n(arst_n), .cfg_enter(cfg_enter), .cmd_valid(cmd_valid), .cmd(cmd),
    .serial_number(serial_number), .fuse_rd(fuse_rd), .fuse_locked(fuse_locked), .hs_valid(hs_valid),
    .hs_frame(hs_frame), .in_config(in_config), .programming(programming), .otp_locked(otp_locked),
    .phase1_start(phase1_start), .fuse_we(fuse_we), .fuse_addr(fuse_addr), .fuse_data(fuse_data),
    .config_reg_a(config_reg_a), .config_reg_b(config_reg_b), .config_reg_c(config_reg_c));
  fuse_model fuse_model_inst (.clk(clk), .fuse_we(fuse_we), .fuse_addr(fuse_addr), .fuse_data(fuse_data),
    .fuse_rd(fuse_rd), .fuse_locked(fuse_locked));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic issue(input logic rw, input logic [3:0] a, input logic [7:0] d, input logic bad);
    @(posedge clk);
    cmd <= '{parity: (^{d, a, rw}) ^ bad, data: d, addr: a, rw: rw};
    cmd_valid <= 1'b1;
  endtask

  // counts edges and fuse burns until a handshake shows; bounded
  task automatic wait_hs(input int bound, input bit want);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      cfg_enter <= 1'b0;
      #1;
      n_cyc++;
      n_we += fuse_we;
      if (hs_valid === 1'b1) begin
        hs = hs_frame;
        if (want) return;
        check(hs_valid, 1'b0);
      end
    end
    if (want) begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic hs_chk(input logic [3:0] a, input logic [7:0] d, input logic [2:0] sv);
    check(hs.addr, a);
    check(hs.data, d);
    check(hs.sv, sv);
    check(hs.start, cfg_otp_pkg::START_BITS);
    check(^hs[17:2], 1'b0);
  endtask

  task automatic send(input logic rw, input logic [3:0] a, input logic [7:0] d, input logic bad);
    issue(rw, a, d, bad);
    n_cyc = 0;
    wait_hs(4, 1'b1);
    check(n_cyc, 1);
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic enter(input logic [7:0] creg_c);
    @(posedge clk);
    cfg_enter <= 1'b1;
    n_cyc = 0;
    wait_hs(4, 1'b1);
    hs_chk(cfg_otp_pkg::ADDR_CFG_C, creg_c, cfg_otp_pkg::SV_NORMAL);
    check(in_config, 1'b1);
  endtask

  task automatic basic();
    send(1'b0, cfg_otp_pkg::ADDR_CFG_A, 8'h55, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_CFG_A, 8'h55, cfg_otp_pkg::SV_NORMAL);
    check(config_reg_a, 8'h55);
    send(1'b1, cfg_otp_pkg::ADDR_CFG_A, 8'hff, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_CFG_A, 8'h55, cfg_otp_pkg::SV_NORMAL);
    send(1'b0, cfg_otp_pkg::ADDR_CFG_B, 8'h33, 1'b1);
    hs_chk(cfg_otp_pkg::ZERO_ADDR, cfg_otp_pkg::ZERO_BYTE, cfg_otp_pkg::SV_ERROR);
    check(config_reg_b, 8'h00);
    send(1'b0, cfg_otp_pkg::ADDR_EXIT, 8'h01, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_EXIT, 8'h01, cfg_otp_pkg::SV_NORMAL);
    check(in_config, 1'b1);
  endtask

  task automatic ids();
    int k;
    for (k = 0; k < 4; k++) begin
      send(1'b1, cfg_otp_pkg::ADDR_SN0 + 4'(k), 8'h00, 1'b0);
      hs_chk(cfg_otp_pkg::ADDR_SN0 + 4'(k), serial_number[8*k+:8], cfg_otp_pkg::SV_NORMAL);
    end
    send(1'b0, cfg_otp_pkg::ADDR_MFG_ID, 8'h00, 1'b0);
    send(1'b1, cfg_otp_pkg::ADDR_MFG_ID, 8'h00, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_MFG_ID, ID_VAL, cfg_otp_pkg::SV_NORMAL);
  endtask

  task automatic prog_seq();
    logic [7:0] exp_b [4] = '{8'h3c, 8'h55, 8'h00, 8'h81};
    int k;
    send(1'b0, cfg_otp_pkg::ADDR_USER, 8'h3c, 1'b0);
    issue(1'b0, cfg_otp_pkg::ADDR_CFG_C, 8'h81, 1'b0);
    n_cyc = 0;
    n_we = 0;
    wait_hs(3, 1'b0);
    check(programming, 1'b1);
    issue(1'b1, cfg_otp_pkg::ADDR_CFG_A, 8'h00, 1'b0);
    wait_hs(40, 1'b1);
    check((n_cyc >= 8 && n_cyc <= 11), 1'b1);
    check(n_we, cfg_otp_pkg::FUSE_BYTES);
    hs_chk(cfg_otp_pkg::ADDR_CFG_C, 8'h81, cfg_otp_pkg::SV_NORMAL);
    check(otp_locked, 1'b1);
    check(programming, 1'b0);
    wait_hs(4, 1'b0);
    check(fuse_rd[0], 8'h3c);
    check(fuse_rd[3], 8'h81);
    check(config_reg_c, 8'h81);
    for (k = 0; k < 4; k++) begin
      send(1'b1, 4'(k), 8'h00, 1'b0);
      hs_chk(4'(k), exp_b[k], cfg_otp_pkg::SV_NORMAL);
    end
  endtask

  task automatic locked();
    send(1'b0, cfg_otp_pkg::ADDR_CFG_A, 8'h00, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_CFG_A, 8'h55, cfg_otp_pkg::SV_NORMAL);
    check(config_reg_a, 8'h55);
  endtask

  task automatic leave();
    send(1'b0, cfg_otp_pkg::ADDR_EXIT, cfg_otp_pkg::EXIT_VALUE, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_EXIT, cfg_otp_pkg::EXIT_VALUE, cfg_otp_pkg::SV_NORMAL);
    check(phase1_start, 1'b1);
    check(in_config, 1'b0);
    repeat (2) @(posedge clk);
    enter(8'h81);
  endtask

  initial begin
    arst_n = 1'b0;
    cfg_enter = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    serial_number = 32'h1357_9bdf;
    do_reset();
    check(in_config, 1'b0);
    enter(8'h00);
    basic();
    ids();
    prog_seq();
    locked();
    leave();
    do_reset();
    enter(8'h81);
    send(1'b1, cfg_otp_pkg::ADDR_USER, 8'h00, 1'b0);
    hs_chk(cfg_otp_pkg::ADDR_USER, 8'h3c, cfg_otp_pkg::SV_NORMAL);
    end_sim();
  end
endmodule
